// ---- design/lcs_pkg.sv ----
// Purpose: Shared constants for the linear charge sequencer
// Assumes: 20 MHz clock, AXI4-Lite register access
// Notes: Offsets are byte addresses of 32-bit words
package lcs_pkg;
  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] LCS_CTRL_OFF = 8'h00;
  localparam logic [7:0] LCS_FAST_CHARGE_CURRENT_FIELD_OFF = 8'h04;
  localparam logic [7:0] LCS_BATTERY_TARGET_VOLTAGE_OFF = 8'h08;
  localparam logic [7:0] LCS_TMR_OFF = 8'h0c;
  localparam logic [7:0] LCS_STAT_OFF = 8'h10;
  localparam logic [7:0] LCS_IRQ_OFF = 8'h14;
  localparam logic [7:0] LCS_MASK_OFF = 8'h18;
  // Control register fields
  localparam int LCS_CTRL_DIS_BIT = 0;
  localparam int LCS_CTRL_TRK_BIT = 1;
  localparam int LCS_CTRL_TERMEN_BIT = 2;
  localparam int LCS_CTRL_T2X_BIT = 3;
  localparam logic [3:0] LCS_CTRL_RST = 4'h4;
  // Current fields, 10 bits, one code per mA step
  localparam int LCS_IW = 10;
  localparam logic [9:0] LCS_FAST_CHARGE_CURRENT_FIELD_RST = 10'h064;
  localparam logic [9:0] LCS_IPRE_RST = 10'h00a;
  localparam logic [9:0] LCS_ITRK_HI = 10'h008;
  localparam logic [9:0] LCS_ITRK_LO = 10'h001;
  // Target voltage in 10 mV codes; 4.65 V ceiling
  localparam int LCS_VW = 9;
  localparam logic [8:0] LCS_BATTERY_TARGET_VOLTAGE_MAX = 9'h1d1;
  localparam logic [8:0] LCS_BATTERY_TARGET_VOLTAGE_RST = 9'h1a4;
  // Safety timer, minutes
  localparam logic [9:0] LCS_TMR_RST = 10'h0b4;
  localparam int LCS_CLK_HZ = 20000000;
  localparam int LCS_SEC_CYC = LCS_CLK_HZ;
  // Charge state codes
  localparam logic [1:0] LCS_CS_OFF = 2'b00;
  localparam logic [1:0] LCS_CS_PRE = 2'b01;
  localparam logic [1:0] LCS_CS_FAST = 2'b10;
  localparam logic [1:0] LCS_CS_DONE = 2'b11;
  // Interrupt bits
  localparam int LCS_IRQ_DONE = 0;
  localparam int LCS_IRQ_FAULT = 1;
  localparam int LCS_IRQ_RECHG = 2;
  typedef enum logic [4:0] {
    LCS_IDLE = 5'b00001,
    LCS_PRE = 5'b00010,
    LCS_FAST = 5'b00100,
    LCS_DONE = 5'b01000,
    LCS_FAULT = 5'b10000
  } lcs_state_e;
endpackage : lcs_pkg

// ---- design/lcs_tick.sv ----
// Purpose: Minute tick divider with optional half rate
// Assumes: Single clock, synchronous active-low reset
// Notes: Pulse is one cycle wide
`timescale 1ns/10ps
module lcs_tick
  import lcs_pkg::*;
#(
  parameter int MIN_CYC = 60 * LCS_SEC_CYC
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic run,
  input wire logic half,
  output logic tick
);
  logic [31:0] cnt_reg;
  logic slow_reg;
  always_ff @(posedge aclk) begin
    if (!aresetn || !run) begin
      cnt_reg <= '0;
      slow_reg <= 1'b0;
      tick <= 1'b0;
    end else if (cnt_reg >= 32'(MIN_CYC - 1)) begin
      cnt_reg <= '0;
      slow_reg <= half ? ~slow_reg : 1'b0;
      // Half rate skips every other minute
      tick <= !half || slow_reg;
    end else begin
      cnt_reg <= cnt_reg + 32'd1;
      tick <= 1'b0;
    end
  end
endmodule : lcs_tick

// ---- design/lcs_seq.sv ----
// Purpose: Charge sequencer with AXI4-Lite registers
// Assumes: Analog comparators arrive synchronous to aclk
// Notes: Currents are codes to the analog loops
// Operation
// - Charge only with disable bit 0, pin low
// - Disabled keeps battery switch off always
// - New cycle needs valid input supply
// - Below short threshold use trickle current
// - Trickle/precharge timer is quarter of fast
// - Between thresholds use programmed precharge current
// - At fast threshold enter fast charge
// - Termination off: precharge is fast/5
// - Fast current unless a limiting loop acts
// - Charge done reports state code b11
// - Clamp target voltage to 4.65 V
// - Host-writable fast current control register
// - Termination opens battery switch, high impedance
// - Terminate only under constant-voltage control
// - Recharge threshold restarts cycle, resets timers
// - Timer double with input limiting halves rate
// - No termination in supplement mode
//
// Chosen here: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
module lcs_seq
  import lcs_pkg::*;
#(
  parameter int MIN_CYC = 60 * LCS_SEC_CYC
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic charge_enable_n,
  input wire logic input_valid,
  input wire logic below_short_battery,
  input wire logic below_fast_charge,
  input wire logic at_recharge_threshold,
  input wire logic cv_loop_active,
  input wire logic at_termination_current,
  input wire logic input_voltage_limiting,
  input wire logic power_path_limiting,
  input wire logic input_current_limit,
  input wire logic thermal_regulation,
  input wire logic thermistor_fault,
  input wire logic supplement_mode,
  output logic battery_switch,
  output logic [9:0] charge_current,
  output logic [8:0] battery_target_voltage,
  output logic [1:0] charge_state_field,
  output logic irq
);
  // ----------------------------------------------------------------
  // Registers and helpers
  // ----------------------------------------------------------------
  logic [3:0] ctrl_reg, wstrb_reg;
  logic [9:0] fast_charge_current_field_reg, ipre_reg, tmr_reg;
  logic [8:0] battery_target_voltage_reg;
  logic [2:0] irq_reg, mask_reg, ev_set;
  lcs_state_e st_reg, st_next;
  logic [11:0] min_reg;
  logic [7:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic tick, aw_hold_reg, w_hold_reg, charge_ok, limiting, term_ok, tmr_expired, wr_go;
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction : merge

  assign charge_ok = !ctrl_reg[LCS_CTRL_DIS_BIT] && !charge_enable_n;
  assign limiting = input_voltage_limiting || power_path_limiting || input_current_limit || thermal_regulation;
  assign term_ok = ctrl_reg[LCS_CTRL_TERMEN_BIT] && cv_loop_active && at_termination_current
                   && !limiting && !supplement_mode;
  // Precharge budget is a quarter of the fast setting
  assign tmr_expired = (st_reg == LCS_PRE) ? (min_reg >= {2'b00, tmr_reg} >> 2)
                                           : (min_reg >= {2'b00, tmr_reg});
  // ----------------------------------------------------------------
  // Safety timer
  // ----------------------------------------------------------------
  lcs_tick #(.MIN_CYC(MIN_CYC)) u_tick (
    .aclk(aclk),
    .aresetn(aresetn),
    .run(st_reg == LCS_PRE || st_reg == LCS_FAST),
    .half(ctrl_reg[LCS_CTRL_T2X_BIT] && input_voltage_limiting),
    .tick(tick)
  );

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      min_reg <= '0;
    end else if (st_reg == LCS_IDLE || st_reg == LCS_DONE || (st_reg == LCS_PRE && st_next == LCS_FAST)) begin
      min_reg <= '0;
    end else if (tick && min_reg != '1) begin
      min_reg <= min_reg + 12'd1;
    end
  end
  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_comb begin
    st_next = st_reg;
    unique case (st_reg)
      LCS_IDLE: begin
        if (charge_ok && input_valid) begin
          st_next = below_fast_charge ? LCS_PRE : LCS_FAST;
        end
      end
      LCS_PRE: begin
        if (!charge_ok || !input_valid) begin
          st_next = LCS_IDLE;
        end else if (tmr_expired) begin
          st_next = LCS_FAULT;
        end else if (!below_fast_charge) begin
          st_next = LCS_FAST;
        end
      end
      LCS_FAST: begin
        if (!charge_ok || !input_valid) begin
          st_next = LCS_IDLE;
        end else if (term_ok) begin
          st_next = LCS_DONE;
        end else if (tmr_expired) begin
          st_next = LCS_FAULT;
        end
      end
      LCS_DONE: begin
        if (!charge_ok) begin
          st_next = LCS_IDLE;
        end else if (at_recharge_threshold && input_valid) begin
          st_next = below_fast_charge ? LCS_PRE : LCS_FAST;
        end
      end
      LCS_FAULT: begin
        // Fault holds until charging is toggled off
        if (!charge_ok) begin
          st_next = LCS_IDLE;
        end
      end
      default: st_next = LCS_IDLE;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_reg <= LCS_IDLE;
    end else begin
      st_reg <= st_next;
    end
  end
  // ----------------------------------------------------------------
  // Analog-facing outputs
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      battery_switch <= 1'b0;
      charge_current <= '0;
      charge_state_field <= LCS_CS_OFF;
      battery_target_voltage <= LCS_BATTERY_TARGET_VOLTAGE_RST;
    end else begin
      battery_target_voltage <= (battery_target_voltage_reg > LCS_BATTERY_TARGET_VOLTAGE_MAX) ? LCS_BATTERY_TARGET_VOLTAGE_MAX : battery_target_voltage_reg;
      battery_switch <= charge_ok && (st_next == LCS_PRE || st_next == LCS_FAST);
      unique case (st_next)
        LCS_PRE: begin
          charge_state_field <= LCS_CS_PRE;
          if (below_short_battery) begin
            charge_current <= ctrl_reg[LCS_CTRL_TRK_BIT] ? LCS_ITRK_HI : LCS_ITRK_LO;
          end else if (!ctrl_reg[LCS_CTRL_TERMEN_BIT]) begin
            charge_current <= 10'(fast_charge_current_field_reg / 10'd5);
          end else begin
            charge_current <= ipre_reg;
          end
        end
        LCS_FAST: begin
          charge_state_field <= LCS_CS_FAST;
          // Limiting loops own the current themselves; code is the ceiling
          charge_current <= (thermistor_fault || limiting) ? fast_charge_current_field_reg : fast_charge_current_field_reg;
        end
        LCS_DONE: begin
          charge_state_field <= LCS_CS_DONE;
          charge_current <= '0;
        end
        default: begin
          charge_state_field <= LCS_CS_OFF;
          charge_current <= '0;
        end
      endcase
    end
  end
  // ----------------------------------------------------------------
  // Interrupts
  // ----------------------------------------------------------------
  assign ev_set[LCS_IRQ_DONE] = (st_reg != LCS_DONE) && (st_next == LCS_DONE);
  assign ev_set[LCS_IRQ_FAULT] = (st_reg != LCS_FAULT) && (st_next == LCS_FAULT);
  assign ev_set[LCS_IRQ_RECHG] = (st_reg == LCS_DONE) && (st_next == LCS_PRE || st_next == LCS_FAST);
  assign wr_go = aw_hold_reg && w_hold_reg && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_reg <= '0;
    end else if (wr_go && awaddr_reg == LCS_IRQ_OFF && wstrb_reg[0]) begin
      // Set wins over a write-one clear in the same cycle
      irq_reg <= (irq_reg & ~wdata_reg[2:0]) | ev_set;
    end else begin
      irq_reg <= irq_reg | ev_set;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_reg & mask_reg);
    end
  end
  // ----------------------------------------------------------------
  // AXI4-Lite write
  // ----------------------------------------------------------------
  // Ready flops track: channel not held and no response pending
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_reg <= 1'b0;
      w_hold_reg <= 1'b0;
      awaddr_reg <= '0;
      wdata_reg <= '0;
      wstrb_reg <= '0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_reg <= 1'b1;
        s_axi_awready <= 1'b0;
        awaddr_reg <= {s_axi_awaddr[7:2], 2'b00};
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_reg <= 1'b1;
        s_axi_wready <= 1'b0;
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_hold_reg <= 1'b0;
        w_hold_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (awaddr_reg <= LCS_MASK_OFF) ? 2'b00 : 2'b10;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_reg <= LCS_CTRL_RST;
      fast_charge_current_field_reg <= LCS_FAST_CHARGE_CURRENT_FIELD_RST;
      ipre_reg <= LCS_IPRE_RST;
      battery_target_voltage_reg <= LCS_BATTERY_TARGET_VOLTAGE_RST;
      tmr_reg <= LCS_TMR_RST;
      mask_reg <= '0;
    end else if (wr_go) begin
      unique case (awaddr_reg)
        LCS_CTRL_OFF: ctrl_reg <= 4'(merge({28'h0, ctrl_reg}, wdata_reg, wstrb_reg));
        LCS_FAST_CHARGE_CURRENT_FIELD_OFF: begin
          fast_charge_current_field_reg <= 10'(merge({22'h0, fast_charge_current_field_reg}, wdata_reg, wstrb_reg));
          ipre_reg <= 10'(merge({6'h0, ipre_reg, 16'h0}, wdata_reg, wstrb_reg) >> 16);
        end
        LCS_BATTERY_TARGET_VOLTAGE_OFF: battery_target_voltage_reg <= 9'(merge({23'h0, battery_target_voltage_reg}, wdata_reg, wstrb_reg));
        LCS_TMR_OFF: tmr_reg <= 10'(merge({22'h0, tmr_reg}, wdata_reg, wstrb_reg));
        LCS_MASK_OFF: mask_reg <= 3'(merge({29'h0, mask_reg}, wdata_reg, wstrb_reg));
        default: ;
      endcase
    end
  end
  // ----------------------------------------------------------------
  // AXI4-Lite read
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= 2'b00;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= 2'b00;
      unique case ({s_axi_araddr[7:2], 2'b00})
        LCS_CTRL_OFF: s_axi_rdata <= {28'h0, ctrl_reg};
        LCS_FAST_CHARGE_CURRENT_FIELD_OFF: s_axi_rdata <= {6'h0, ipre_reg, 6'h0, fast_charge_current_field_reg};
        LCS_BATTERY_TARGET_VOLTAGE_OFF: s_axi_rdata <= {23'h0, battery_target_voltage_reg};
        LCS_TMR_OFF: s_axi_rdata <= {22'h0, tmr_reg};
        LCS_STAT_OFF: s_axi_rdata <= {15'h0, st_reg, min_reg};
        LCS_IRQ_OFF: s_axi_rdata <= {29'h0, irq_reg};
        LCS_MASK_OFF: s_axi_rdata <= {29'h0, mask_reg};
        default: begin
          s_axi_rdata <= '0;
          s_axi_rresp <= 2'b10;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end
  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_disable_off;
    @(posedge aclk) disable iff (!aresetn) !charge_ok |=> !battery_switch;
  endproperty
  a_disable_off: assert property (p_disable_off) else $error("switch on while disabled");
  property p_clamp;
    @(posedge aclk) disable iff (!aresetn) battery_target_voltage <= LCS_BATTERY_TARGET_VOLTAGE_MAX;
  endproperty
  a_clamp: assert property (p_clamp) else $error("target above ceiling");
  property p_done_code;
    @(posedge aclk) disable iff (!aresetn) (st_reg == LCS_DONE) |-> charge_state_field == LCS_CS_DONE;
  endproperty
  a_done_code: assert property (p_done_code) else $error("done code wrong");
  property p_done_open;
    @(posedge aclk) disable iff (!aresetn) (st_reg == LCS_DONE) |-> !battery_switch;
  endproperty
  a_done_open: assert property (p_done_open) else $error("switch on after done");
  property p_no_term_limit;
    @(posedge aclk) disable iff (!aresetn) (st_reg == LCS_FAST && (limiting || supplement_mode)) |=> st_reg != LCS_DONE;
  endproperty
  a_no_term_limit: assert property (p_no_term_limit) else $error("terminated under limit");
  property p_fault;
    @(posedge aclk) disable iff (!aresetn) $rose(st_reg == LCS_FAULT) |=> irq_reg[LCS_IRQ_FAULT] && !battery_switch;
  endproperty
  a_fault: assert property (p_fault) else $error("fault not flagged");
  property p_trickle;
    @(posedge aclk) disable iff (!aresetn) (st_reg == LCS_PRE && st_next == LCS_PRE && below_short_battery)
      |=> charge_current == LCS_ITRK_HI || charge_current == LCS_ITRK_LO;
  endproperty
  a_trickle: assert property (p_trickle) else $error("trickle current wrong");
  property p_idle_valid;
    @(posedge aclk) disable iff (!aresetn) (st_reg == LCS_IDLE && !input_valid) |=> st_reg == LCS_IDLE;
  endproperty
  a_idle_valid: assert property (p_idle_valid) else $error("cycle started without input");
endmodule : lcs_seq

// ---- tb/lcs_batt_model.sv ----
// Purpose: Cell model giving the comparator levels the sequencer sees
// Assumes: Bench picks the cell condition through a level code
// Notes: 0 deep, 1 low, 2 cc, 3 cv, 4 taper end, 5 sagged after done
`timescale 1ns/10ps
module lcs_batt_model (
  input wire logic [2:0] level,
  output logic below_short_battery,
  output logic below_fast_charge,
  output logic cv_loop_active,
  output logic at_termination_current,
  output logic at_recharge_threshold
);
  assign below_short_battery = (level == 3'h0);
  assign below_fast_charge = (level <= 3'h1);
  // Taper end only ever seen with the voltage loop in control
  assign cv_loop_active = (level == 3'h3) || (level == 3'h4);
  assign at_termination_current = (level == 3'h4);
  assign at_recharge_threshold = (level == 3'h5);
endmodule : lcs_batt_model

// ---- tb/lcs_seq_tb.sv ----
// Purpose: Self-checking bench for the charge sequencer
// Assumes: Minute divider shortened to 20 cycles
// Notes: All drives but the reset release land 1 ns after a rising edge
`timescale 1ns/10ps
module lcs_seq_tb;
  import lcs_pkg::*;
  // ----------------------------------------------------------------
  // Signals and instances
  // ----------------------------------------------------------------
  logic aclk = '0, aresetn = '0;
  logic [7:0] awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0, rdata, d;
  logic [3:0] wstrb = 4'hf;
  logic awvalid = '0, wvalid = '0, bready = '0, arvalid = '0, rready = '0;
  logic awready, wready, bvalid, arready, rvalid, sw, irq, bs, bf, cv, at_t, at_r;
  logic [1:0] bresp, rresp, cs, r;
  logic [9:0] cur;
  logic [8:0] vt;
  logic en_n = 1'h1, vin_ok = 1'h1, therm = 1'h0;
  logic [4:0] lim = '0;
  logic [2:0] level = '0;
  int n_mismatch = 0, num_checks = 0, n, i;
  always #25 aclk = ~aclk;
  lcs_seq #(.MIN_CYC(20)) lcs_seq_inst (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .charge_enable_n(en_n),
    .input_valid(vin_ok), .below_short_battery(bs), .below_fast_charge(bf),
    .at_recharge_threshold(at_r), .cv_loop_active(cv), .at_termination_current(at_t),
    .input_voltage_limiting(lim[0]), .power_path_limiting(lim[1]), .input_current_limit(lim[2]),
    .thermal_regulation(lim[3]), .thermistor_fault(therm), .supplement_mode(lim[4]),
    .battery_switch(sw), .charge_current(cur), .battery_target_voltage(vt),
    .charge_state_field(cs), .irq(irq)
  );
  lcs_batt_model lcs_batt_model_inst (
    .level(level), .below_short_battery(bs), .below_fast_charge(bf), .cv_loop_active(cv),
    .at_termination_current(at_t), .at_recharge_threshold(at_r)
  );
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic final_report;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : final_report
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic hang;
    n_mismatch++;
    $display("unexpected wait bound used up");
    final_report();
  endtask : hang
  task automatic tick(input int k);
    repeat (k) @(posedge aclk);
    #1;
  endtask : tick
  task automatic wait_cs(input logic [1:0] e, input int b, output int k);
    for (k = 0; k < b && cs !== e; k++) tick(1);
    if (cs !== e) hang();
  endtask : wait_cs
  // Each channel let go only after the edge that took it
  task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] q);
    logic ta, tw, tb;
    int k;
    tb = 1'h0;
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    for (k = 0; k < 40 && tb !== 1'h1; k++) begin
      #1;
      ta = awvalid & awready;
      tw = wvalid & wready;
      tb = bvalid & bready;
      q = bresp;
      tick(1);
      if (ta === 1'h1) awvalid <= 1'h0;
      if (tw === 1'h1) wvalid <= 1'h0;
    end
    bready <= 1'h0;
    if (tb !== 1'h1) hang();
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] q);
    logic ta, tr;
    int k;
    tr = 1'h0;
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    for (k = 0; k < 40 && tr !== 1'h1; k++) begin
      #1;
      ta = arvalid & arready;
      tr = rvalid & rready;
      v = rdata;
      q = rresp;
      tick(1);
      if (ta === 1'h1) arvalid <= 1'h0;
    end
    rready <= 1'h0;
    if (tr !== 1'h1) hang();
  endtask : rd
  task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] v;
    logic [1:0] q;
    rd(a, v, q);
    chk(nm, e, v);
  endtask : rchk
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    rchk("ctrl", LCS_CTRL_OFF, 32'h0000_0004);
    rchk("fast_charge_current_field", LCS_FAST_CHARGE_CURRENT_FIELD_OFF, 32'h000a_0064);
    rchk("battery_target_voltage", LCS_BATTERY_TARGET_VOLTAGE_OFF, 32'h0000_01a4);
    rchk("tmr", LCS_TMR_OFF, 32'h0000_00b4);
    rchk("mask", LCS_MASK_OFF, 32'h0000_0000);
    rd(8'h1c, d, r);
    chk("unmapped resp", 32'h0000_0002, r);
    wr(8'h1c, 32'h0000_0001, r);
    chk("unmapped wr resp", 32'h0000_0002, r);
    chk("state", LCS_CS_OFF, cs);
    $display("t_reset done");
  endtask : t_reset
  task automatic t_enable;
    tick(4);
    chk("sw pin high", 1'h0, sw);
    wr(LCS_CTRL_OFF, 32'h0000_0005, r);
    chk("wr resp", 32'h0000_0000, r);
    en_n <= 1'h0;
    tick(4);
    chk("sw bit set", 1'h0, sw);
    vin_ok <= 1'h0;
    wr(LCS_CTRL_OFF, 32'h0000_0004, r);
    tick(4);
    chk("sw no input", 1'h0, sw);
    vin_ok <= 1'h1;
    wait_cs(LCS_CS_PRE, 10, n);
    tick(1);
    chk("sw on", 1'h1, sw);
    chk("trickle lo", 10'h001, cur);
    $display("t_enable done");
  endtask : t_enable
  task automatic t_phases;
    wr(LCS_CTRL_OFF, 32'h0000_0006, r);
    tick(2);
    chk("trickle hi", 10'h008, cur);
    level <= 3'h1;
    tick(2);
    chk("precharge", 10'h00a, cur);
    chk("state pre", LCS_CS_PRE, cs);
    wr(LCS_CTRL_OFF, 32'h0000_0002, r);
    tick(2);
    chk("pre fifth", 10'h014, cur);
    wr(LCS_CTRL_OFF, 32'h0000_0006, r);
    level <= 3'h2;
    wait_cs(LCS_CS_FAST, 5, n);
    tick(1);
    chk("fast cur", 10'h064, cur);
    $display("t_phases done");
  endtask : t_phases
  task automatic t_term;
    wr(LCS_FAST_CHARGE_CURRENT_FIELD_OFF, 32'h000a_0050, r);
    lim[0] <= 1'h1;
    therm <= 1'h1;
    tick(2);
    chk("fast_charge_current_field new", 10'h050, cur);
    wr(LCS_BATTERY_TARGET_VOLTAGE_OFF, 32'h0000_01ff, r);
    tick(2);
    chk("clamp", 9'h1d1, vt);
    level <= 3'h4;
    for (i = 0; i < 5; i++) begin
      lim <= 5'h01 << i;
      tick(4);
      chk("no term limited", LCS_CS_FAST, cs);
    end
    lim <= 5'h00;
    therm <= 1'h0;
    wait_cs(LCS_CS_DONE, 5, n);
    tick(2);
    chk("sw term", 1'h0, sw);
    chk("irq masked", 1'h0, irq);
    rchk("irq stat", LCS_IRQ_OFF, 32'h0000_0001);
    wr(LCS_MASK_OFF, 32'h0000_0007, r);
    tick(2);
    chk("irq done", 1'h1, irq);
    wr(LCS_IRQ_OFF, 32'h0000_0001, r);
    tick(2);
    chk("irq clr", 1'h0, irq);
    $display("t_term done");
  endtask : t_term
  task automatic t_rechg;
    level <= 3'h5;
    wait_cs(LCS_CS_FAST, 5, n);
    tick(1);
    chk("sw rechg", 1'h1, sw);
    rd(LCS_STAT_OFF, d, r);
    chk("timer reset", 12'h000, d[11:0]);
    chk("irq rechg", 1'h1, irq);
    wr(LCS_IRQ_OFF, 32'h0000_0004, r);
    $display("t_rechg done");
  endtask : t_rechg
  // Precharge limit is one minute here, fast limit four
  task automatic t_fault;
    en_n <= 1'h1;
    wr(LCS_TMR_OFF, 32'h0000_0004, r);
    level <= 3'h1;
    tick(3);
    en_n <= 1'h0;
    wait_cs(LCS_CS_PRE, 5, n);
    wait_cs(LCS_CS_OFF, 60, n);
    chk("pre timer", 1'h1, n >= 15 && n <= 30);
    tick(2);
    chk("sw fault", 1'h0, sw);
    chk("irq fault", 1'h1, irq);
    wr(LCS_IRQ_OFF, 32'h0000_0002, r);
    en_n <= 1'h1;
    wr(LCS_CTRL_OFF, 32'h0000_000e, r);
    lim[0] <= 1'h1;
    tick(2);
    en_n <= 1'h0;
    wait_cs(LCS_CS_PRE, 5, n);
    wait_cs(LCS_CS_OFF, 90, n);
    chk("double timer", 1'h1, n >= 35 && n <= 60);
    $display("t_fault done");
  endtask : t_fault
  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'h1;
    tick(1);
    t_reset();
    t_enable();
    t_phases();
    t_term();
    t_rechg();
    t_fault();
    final_report();
  end
endmodule : lcs_seq_tb
